// file: rtl/tol_pkg.sv
// package with constants and types of the tachometer output logic
package tol_pkg;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int US_PS = 1000000;
	localparam int US_CYCLES = (US_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MS_US = 1000;
	localparam int VAL_W = 20;
	localparam logic [9:0] GATE_1S_MS = 10'h3E8;
	localparam logic [9:0] GATE_200_MS = 10'h0C8;
	localparam logic [9:0] GATE_CONT_MS = 10'h00A;
	localparam logic [6:0] SCALE_1S = 7'h01;
	localparam logic [6:0] SCALE_200 = 7'h05;
	localparam logic [6:0] SCALE_CONT = 7'h64;
	localparam logic [4:0] PW_OFF_MIN_MS = 5'h14;
	localparam logic [19:0] VAL_MAX = 20'hF423F;
	localparam logic [19:0] UB_MIN = 20'h00001;
	localparam logic [19:0] PEAK_RST = 20'h00000;
	localparam logic [19:0] BOTTOM_RST = 20'hF423F;
	localparam logic [19:0] SV_RST = 20'h00000;
	localparam logic [13:0] ALARM_MAX = 14'h270F;
	localparam logic [13:0] KILO_SAT = 14'h3FFF;
	localparam logic [9:0] ON_DIV_M1 = 10'h3E7;
	typedef enum logic [1:0] {
		TOL_IV_1S = 2'h0,
		TOL_IV_200MS = 2'h1,
		TOL_IV_CONT = 2'h2
	} tol_interval_t;
	typedef enum logic [1:0] {
		TOL_DARK = 2'h0,
		TOL_RED = 2'h1,
		TOL_GREEN = 2'h2,
		TOL_ORANGE = 2'h3
	} tol_colour_t;
	typedef enum logic [3:0] {
		TOL_CS_RED = 4'h0,
		TOL_CS_GREEN = 4'h1,
		TOL_CS_ORANGE = 4'h2,
		TOL_CS_R_G = 4'h3,
		TOL_CS_G_R = 4'h4,
		TOL_CS_R_O = 4'h5,
		TOL_CS_O_R = 4'h6,
		TOL_CS_G_O = 4'h7,
		TOL_CS_O_G = 4'h8
	} tol_colour_sel_t;
	typedef struct packed {
		logic sourcing;
		logic pulse_width;
		logic unit_period;
		tol_interval_t interval;
		logic area_mode;
		logic hold_en;
		logic stage_alloc;
		tol_colour_sel_t colour_sel;
	} tol_cfg_t;
	typedef struct packed {
		logic wr;
		logic stage;
		logic [19:0] value;
	} tol_sv_wr_t;
	typedef struct packed {
		logic [13:0] kilo;
		logic [9:0] units;
	} tol_oncount_t;
endpackage

// file: rtl/tol_on_counter.sv
// output on-count accumulator with kilo monitor and alarm
`timescale 1ns/1ps
module tol_on_counter
	import tol_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic out_state_i,
	input wire logic load_i,
	input wire tol_pkg::tol_oncount_t restore_i,
	input wire logic [13:0] threshold_i,
	output tol_pkg::tol_oncount_t count_o,
	output logic alarm_o
);
	logic prev;
	tol_oncount_t cnt;
	wire rise = out_state_i & ~prev;
	wire unit_wrap = cnt.units == ON_DIV_M1;
	wire over = (cnt.kilo > threshold_i) || ((cnt.kilo == threshold_i) && (cnt.units != 10'h000));
	always_ff @(posedge mclk_i)
		if (sys_rst_i)
			prev <= 1'b0;
		else
			prev <= out_state_i;
	always_ff @(posedge mclk_i)
		if (sys_rst_i)
			cnt <= '0;
		else if (load_i)
			cnt <= restore_i;
		else if (rise && cnt.kilo != KILO_SAT)
		begin
			cnt.units <= unit_wrap ? 10'h000 : cnt.units + 10'h001;
			cnt.kilo <= unit_wrap ? cnt.kilo + 14'h0001 : cnt.kilo;
		end
	always_ff @(posedge mclk_i)
		if (sys_rst_i)
			alarm_o <= 1'b0;
		else
			alarm_o <= (threshold_i != 14'h0000) && over;
	assign count_o = cnt;
	AST_ALARM_OFF_AT_ZERO: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		threshold_i == 14'h0000 |=> !alarm_o)
		else $error("alarm raised with zero threshold");
	AST_ONE_PER_EDGE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		rise && !load_i && cnt.kilo != KILO_SAT |=> cnt != $past(cnt))
		else $error("on count missed a rising output");
endmodule

// file: rtl/tol_top.sv
// tachometer measurement, control outputs, colour and on-count logic
//
// Operation
// - startup interval inhibits measurement and outputs
// - one polarity setting for all inputs
// - fixed red, green or orange colour
// - red/green pairs switch on any output
// - orange pairs switch on any output
// - area mode uses output one only
// - bottom tracked from counting start, peak across starts
// - peak value survives power loss
// - hysteresis band stops output chatter
// - output turn-off delayed by set time
// - measurement runs during off delay
// - setpoint upper bound between 1 and 999999
// - allocation swaps transistor and second output
// - pulse cycle mode counts per second
// - pulse width mode times on phase
// - no pulse keeps last width value
// - display unit picks hertz or period
// - 1 s, 200 ms or continuous 10 ms interval
// - alarm threshold 0..9999 thousands, 0 off
// - count above threshold raises alarm
// - on-count monitor shows count/1000
`timescale 1ns/1ps
module tol_top
	import tol_pkg::*;
#(
	parameter int US_CYC = US_CYCLES
)
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic count_in_i,
	input wire tol_pkg::tol_cfg_t cfg_i,
	input wire logic cfg_change_i,
	input wire logic run_mode_i,
	input wire logic [15:0] startup_time_ms_i,
	input wire logic [19:0] hysteresis_i,
	input wire logic [15:0] off_delay_ms_i,
	input wire logic ub_wr_i,
	input wire logic [19:0] ub_value_i,
	input wire tol_pkg::tol_sv_wr_t sv_wr_i,
	input wire logic [13:0] alarm_thr_one_i,
	input wire logic [13:0] alarm_thr_two_i,
	input wire logic nv_load_i,
	input wire logic [19:0] nv_peak_i,
	input wire tol_pkg::tol_oncount_t nv_count_one_i,
	input wire tol_pkg::tol_oncount_t nv_count_two_i,
	output logic startup_done_o,
	output logic meas_stb_o,
	output logic [19:0] meas_value_o,
	output logic [19:0] peak_o,
	output logic [19:0] bottom_o,
	output logic [19:0] stage_one_setpoint_o,
	output logic [19:0] stage_two_setpoint_o,
	output logic [19:0] setpoint_upper_bound_o,
	output logic control_output_one_o,
	output logic control_output_two_o,
	output logic transistor_out_o,
	output logic second_out_o,
	output tol_pkg::tol_colour_t colour_o,
	output tol_pkg::tol_oncount_t on_count_one_o,
	output tol_pkg::tol_oncount_t on_count_two_o,
	output logic count_alarm_o
);
	import tol_pkg::*;

	typedef enum logic [1:0] {
		ST_INHIBIT = 2'b01,
		ST_RUN = 2'b10
	} tol_state_t;

	tol_state_t state;
	tol_state_t next_state;
	logic [15:0] start_ms;
	logic [7:0] us_cnt;
	logic [9:0] ms_cnt;
	logic in_q;
	logic in_prev;
	logic [9:0] gate_ms;
	logic [19:0] pulses;
	logic [19:0] per_us;
	logic per_arm;
	logic [19:0] wid_us;
	logic [4:0] off_ms;
	logic [19:0] sv [2];
	logic [1:0] cmp_on;
	logic [15:0] dly_ms [2];
	logic [1:0] out_st;
	logic alarm_one;
	logic alarm_two;
	logic cnt_start;
	logic [3:0] pair;

	wire running = state == ST_RUN;
	wire us_tick = us_cnt == 8'(US_CYC - 1);
	wire ms_tick = us_tick && ms_cnt == 10'(MS_US - 1);
	wire in_act = cfg_i.sourcing ? count_in_i : ~count_in_i;
	wire rise = in_q & ~in_prev;
	wire fall = ~in_q & in_prev;
	wire [9:0] gate_len = cfg_i.interval == TOL_IV_CONT ? GATE_CONT_MS :
		cfg_i.interval == TOL_IV_200MS ? GATE_200_MS : GATE_1S_MS;
	wire [6:0] scale = cfg_i.interval == TOL_IV_CONT ? SCALE_CONT :
		cfg_i.interval == TOL_IV_200MS ? SCALE_200 : SCALE_1S;
	wire gate_end = ms_tick && gate_ms == gate_len - 10'h001;
	wire [26:0] freq_raw = pulses * scale;
	wire [19:0] freq = freq_raw > {7'h00, VAL_MAX} ? VAL_MAX : freq_raw[19:0];
	wire hz_stb = running && !cfg_i.pulse_width && !cfg_i.unit_period && gate_end;
	wire per_stb = running && !cfg_i.pulse_width && cfg_i.unit_period && rise && per_arm;
	wire off_ok = off_ms >= PW_OFF_MIN_MS;
	wire pw_stb = running && cfg_i.pulse_width && fall && off_ok;
	wire new_stb = hz_stb | per_stb | pw_stb;
	wire [19:0] new_value = hz_stb ? freq : per_stb ? per_us : wid_us;
	wire [19:0] ub_clamped = ub_value_i < UB_MIN ? UB_MIN : ub_value_i > VAL_MAX ? VAL_MAX : ub_value_i;
	wire [19:0] sv_limit = run_mode_i ? setpoint_upper_bound_o : VAL_MAX;
	wire [19:0] sv_new = sv_wr_i.value > sv_limit ? sv_limit : sv_wr_i.value;
	wire any_on = cfg_i.area_mode ? out_st[0] : (out_st[0] | out_st[1]);
	wire [1:0] colour_off = pair[3:2];
	wire [1:0] colour_on = pair[1:0];
	wire [1:0] next_colour = any_on ? colour_on : colour_off;

	// colour pair for outputs off and on
	always_comb
	begin
		pair = {TOL_RED, TOL_RED};
		unique case (cfg_i.colour_sel)
			TOL_CS_RED: pair = {TOL_RED, TOL_RED};
			TOL_CS_GREEN: pair = {TOL_GREEN, TOL_GREEN};
			TOL_CS_ORANGE: pair = {TOL_ORANGE, TOL_ORANGE};
			TOL_CS_R_G: pair = {TOL_RED, TOL_GREEN};
			TOL_CS_G_R: pair = {TOL_GREEN, TOL_RED};
			TOL_CS_R_O: pair = {TOL_RED, TOL_ORANGE};
			TOL_CS_O_R: pair = {TOL_ORANGE, TOL_RED};
			TOL_CS_G_O: pair = {TOL_GREEN, TOL_ORANGE};
			TOL_CS_O_G: pair = {TOL_ORANGE, TOL_GREEN};
			default: pair = {TOL_RED, TOL_RED};
		endcase
	end

	// startup inhibit sequencing
	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_INHIBIT: if (ms_tick && {1'b0, start_ms} + 17'h00001 >= {1'b0, startup_time_ms_i}) next_state = ST_RUN;
			ST_RUN: next_state = ST_RUN;
		endcase
		if (state == ST_INHIBIT && startup_time_ms_i == 16'h0000)
			next_state = ST_RUN;
	end

	always_ff @(posedge mclk_i)
		if (sys_rst_i)
			state <= ST_INHIBIT;
		else
			state <= next_state;

	always_ff @(posedge mclk_i)
		if (sys_rst_i)
			start_ms <= 16'h0000;
		else if (state == ST_INHIBIT && ms_tick && start_ms != 16'hFFFF)
			start_ms <= start_ms + 16'h0001;

	// microsecond and millisecond time base
	always_ff @(posedge mclk_i)
		if (sys_rst_i)
			us_cnt <= 8'h00;
		else
			us_cnt <= us_tick ? 8'h00 : us_cnt + 8'h01;

	always_ff @(posedge mclk_i)
		if (sys_rst_i)
			ms_cnt <= 10'h000;
		else if (us_tick)
			ms_cnt <= ms_cnt == 10'(MS_US - 1) ? 10'h000 : ms_cnt + 10'h001;

	always_ff @(posedge mclk_i)
		if (sys_rst_i)
		begin
			in_q <= 1'b0;
			in_prev <= 1'b0;
		end
		else
		begin
			in_q <= in_act;
			in_prev <= in_q;
		end

	// pulse cycle count over the gate
	always_ff @(posedge mclk_i)
		if (sys_rst_i || !running || cfg_change_i)
		begin
			gate_ms <= 10'h000;
			pulses <= 20'h00000;
		end
		else
		begin
			if (ms_tick)
				gate_ms <= gate_end ? 10'h000 : gate_ms + 10'h001;
			if (gate_end)
				pulses <= {19'h00000, rise};
			else if (rise && pulses != VAL_MAX)
				pulses <= pulses + 20'h00001;
		end

	// period between rising edges in microseconds
	always_ff @(posedge mclk_i)
		if (sys_rst_i || !running || cfg_change_i)
		begin
			per_us <= 20'h00000;
			per_arm <= 1'b0;
		end
		else if (rise)
		begin
			per_us <= 20'h00000;
			per_arm <= 1'b1;
		end
		else if (us_tick && per_us != VAL_MAX)
			per_us <= per_us + 20'h00001;

	// on-phase width and preceding off time
	always_ff @(posedge mclk_i)
		if (sys_rst_i || !running)
		begin
			wid_us <= 20'h00000;
			off_ms <= 5'h00;
		end
		else
		begin
			if (rise)
				wid_us <= 20'h00000;
			else if (in_q && us_tick && wid_us != VAL_MAX)
				wid_us <= wid_us + 20'h00001;
			if (fall)
				off_ms <= 5'h00;
			else if (!in_q && ms_tick && !off_ok)
				off_ms <= off_ms + 5'h01;
		end

	// displayed value, held between strobes
	always_ff @(posedge mclk_i)
		if (sys_rst_i)
		begin
			meas_value_o <= 20'h00000;
			meas_stb_o <= 1'b0;
		end
		else
		begin
			meas_stb_o <= new_stb;
			if (new_stb)
				meas_value_o <= new_value;
		end

	// peak and bottom hold
	always_ff @(posedge mclk_i)
		if (sys_rst_i)
			cnt_start <= 1'b1;
		else
			cnt_start <= cfg_change_i || (state == ST_INHIBIT && next_state == ST_RUN);

	always_ff @(posedge mclk_i)
		if (sys_rst_i)
		begin
			peak_o <= PEAK_RST;
			bottom_o <= BOTTOM_RST;
		end
		else if (nv_load_i)
			peak_o <= nv_peak_i;
		else if (cnt_start && !cfg_i.hold_en)
		begin
			peak_o <= PEAK_RST;
			bottom_o <= BOTTOM_RST;
		end
		else if (cnt_start)
			bottom_o <= BOTTOM_RST;
		else if (meas_stb_o && cfg_i.hold_en)
		begin
			if (meas_value_o > peak_o)
				peak_o <= meas_value_o;
			if (meas_value_o < bottom_o)
				bottom_o <= meas_value_o;
		end

	// setpoints and their upper bound
	always_ff @(posedge mclk_i)
		if (sys_rst_i)
			setpoint_upper_bound_o <= VAL_MAX;
		else if (ub_wr_i)
			setpoint_upper_bound_o <= ub_clamped;

	always_ff @(posedge mclk_i)
		if (sys_rst_i)
		begin
			sv[0] <= SV_RST;
			sv[1] <= SV_RST;
		end
		else if (sv_wr_i.wr)
			sv[sv_wr_i.stage] <= sv_new;

	// comparison with hysteresis and off delay per stage
	for (genvar i = 0; i < 2; i++)
	begin : g_stage
		wire hit = meas_value_o >= sv[i];
		wire [20:0] low_edge = {1'b0, meas_value_o} + {1'b0, hysteresis_i};
		wire below = low_edge < {1'b0, sv[i]};
		always_ff @(posedge mclk_i)
			if (sys_rst_i || !running)
				cmp_on[i] <= 1'b0;
			else if (hit)
				cmp_on[i] <= 1'b1;
			else if (below)
				cmp_on[i] <= 1'b0;
		always_ff @(posedge mclk_i)
			if (sys_rst_i || !running)
				dly_ms[i] <= 16'h0000;
			else if (cmp_on[i])
				dly_ms[i] <= off_delay_ms_i;
			else if (ms_tick && dly_ms[i] != 16'h0000)
				dly_ms[i] <= dly_ms[i] - 16'h0001;
		always_ff @(posedge mclk_i)
			if (sys_rst_i || !running)
				out_st[i] <= 1'b0;
			else
				out_st[i] <= cmp_on[i] || dly_ms[i] != 16'h0000;
	end

	// physical outputs, colour and status
	always_ff @(posedge mclk_i)
		if (sys_rst_i)
		begin
			transistor_out_o <= 1'b0;
			second_out_o <= 1'b0;
			colour_o <= TOL_RED;
			count_alarm_o <= 1'b0;
		end
		else
		begin
			transistor_out_o <= cfg_i.stage_alloc ? out_st[1] : out_st[0];
			second_out_o <= cfg_i.stage_alloc ? out_st[0] : out_st[1];
			colour_o <= tol_colour_t'(next_colour);
			count_alarm_o <= alarm_one | alarm_two;
		end

	tol_on_counter u_count_one (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.out_state_i(out_st[0]),
		.load_i(nv_load_i),
		.restore_i(nv_count_one_i),
		.threshold_i(alarm_thr_one_i > ALARM_MAX ? ALARM_MAX : alarm_thr_one_i),
		.count_o(on_count_one_o),
		.alarm_o(alarm_one)
	);

	tol_on_counter u_count_two (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.out_state_i(out_st[1]),
		.load_i(nv_load_i),
		.restore_i(nv_count_two_i),
		.threshold_i(alarm_thr_two_i > ALARM_MAX ? ALARM_MAX : alarm_thr_two_i),
		.count_o(on_count_two_o),
		.alarm_o(alarm_two)
	);

	assign startup_done_o = running;
	assign control_output_one_o = out_st[0];
	assign control_output_two_o = out_st[1];
	assign stage_one_setpoint_o = sv[0];
	assign stage_two_setpoint_o = sv[1];

	AST_INHIBIT_QUIET: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		state == ST_INHIBIT |=> ##1 !out_st[0] && !out_st[1] && !meas_stb_o)
		else $error("activity during startup inhibit");
	AST_HYST_HOLD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		running && cmp_on[0] && !g_stage[0].below |=> cmp_on[0] || !running)
		else $error("output dropped inside hysteresis band");
	AST_OFF_DELAY: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		running && $fell(cmp_on[0]) && off_delay_ms_i != 16'h0000 |=> out_st[0] || !running)
		else $error("output ended before off delay");
	AST_BOUND_RANGE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		setpoint_upper_bound_o >= UB_MIN && setpoint_upper_bound_o <= VAL_MAX)
		else $error("upper bound out of range");
	AST_SV_CLAMP: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		sv_wr_i.wr && run_mode_i && !ub_wr_i |=> sv[$past(sv_wr_i.stage)] <= setpoint_upper_bound_o)
		else $error("run-mode setpoint above bound");
	AST_ALLOC_SWAP: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		cfg_i.stage_alloc |=> transistor_out_o == $past(out_st[1]) && second_out_o == $past(out_st[0]))
		else $error("allocation swap wrong");
	AST_FIXED_COLOUR: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		cfg_i.colour_sel == TOL_CS_GREEN |=> colour_o == TOL_GREEN)
		else $error("fixed colour not kept");
	AST_AREA_COLOUR: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		cfg_i.area_mode && cfg_i.colour_sel == TOL_CS_R_G && !out_st[0] && out_st[1] |=> colour_o == TOL_RED)
		else $error("area mode colour uses output two");
	AST_PEAK_TRACK: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		meas_stb_o && cfg_i.hold_en && !cnt_start && !nv_load_i |=> peak_o >= $past(meas_value_o))
		else $error("peak below measured value");
	AST_WIDTH_HOLD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		cfg_i.pulse_width && !new_stb |=> meas_value_o == $past(meas_value_o))
		else $error("width value changed without pulse");
endmodule

// file: verif/tol_sensor_model.sv
// pulse sensor model driving the count input
`timescale 1ns/1ps
module tol_sensor_model
(
	input wire logic mclk_i,
	input wire logic en_i,
	input wire logic sourcing_i,
	input wire logic [15:0] on_cyc_i,
	input wire logic [15:0] off_cyc_i,
	output logic sense_o
);
	logic active = 1'b0;
	logic [15:0] cnt = 16'h0000;
	// off phase first, so every pulse follows a full off time
	always_ff @(posedge mclk_i)
	begin
		if (!en_i)
		begin
			active <= 1'b0;
			cnt <= 16'h0000;
		end
		else if (cnt + 16'h0001 >= (active ? on_cyc_i : off_cyc_i))
		begin
			active <= ~active;
			cnt <= 16'h0000;
		end
		else
			cnt <= cnt + 16'h0001;
	end
	// idle line sits at the inactive level
	assign sense_o = sourcing_i ? active : ~active;
endmodule

// file: verif/tol_top_tb.sv
// self-checking testbench of the tachometer output logic
`timescale 1ns/1ps
module tol_top_tb;
	import tol_pkg::*;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic count_in_i;
	tol_cfg_t cfg_i = '{1'b1, 1'b0, 1'b1, TOL_IV_CONT, 1'b0, 1'b1, 1'b0, TOL_CS_RED};
	logic cfg_change_i = 1'b0;
	logic run_mode_i = 1'b0;
	logic [19:0] hyst = 20'h00064;
	logic [15:0] offd = 16'h0000;
	logic ub_wr_i = 1'b0;
	logic [19:0] ub_value_i = 20'h00000;
	tol_sv_wr_t sv_wr_i = '0;
	logic [13:0] thr1 = 14'h0000;
	logic nv_load_i = 1'b0;
	tol_oncount_t nv1 = '0;
	logic m_en = 1'b1;
	logic m_src = 1'b1;
	logic [15:0] m_on = 16'h0064;
	logic [15:0] m_off = 16'h0384;
	logic startup_done_o, meas_stb_o, control_output_one, control_output_two, trans_o, second_o, count_alarm_o;
	logic [19:0] meas_value_o, peak_o, bottom_o, sv1_o, sv2_o, ub_o;
	tol_colour_t colour_o;
	tol_oncount_t cnt1_o;
	int fail_count = 0;
	int n_tests = 0;
	int cyc;
	tol_colour_t col_off [9] = '{TOL_RED, TOL_GREEN, TOL_ORANGE, TOL_RED, TOL_GREEN, TOL_RED, TOL_ORANGE,
		TOL_GREEN, TOL_ORANGE};
	tol_colour_t col_on [9] = '{TOL_RED, TOL_GREEN, TOL_ORANGE, TOL_GREEN, TOL_RED, TOL_ORANGE, TOL_RED,
		TOL_ORANGE, TOL_GREEN};
	always #2.5 mclk_i = ~mclk_i;
	tol_top #(.US_CYC(1)) uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .count_in_i(count_in_i), .cfg_i(cfg_i),
		.cfg_change_i(cfg_change_i), .run_mode_i(run_mode_i), .startup_time_ms_i(16'h0002),
		.hysteresis_i(hyst), .off_delay_ms_i(offd), .ub_wr_i(ub_wr_i), .ub_value_i(ub_value_i),
		.sv_wr_i(sv_wr_i), .alarm_thr_one_i(thr1), .alarm_thr_two_i(14'h0000), .nv_load_i(nv_load_i),
		.nv_peak_i(20'h12345), .nv_count_one_i(nv1), .nv_count_two_i('0), .startup_done_o(startup_done_o),
		.meas_stb_o(meas_stb_o), .meas_value_o(meas_value_o), .peak_o(peak_o), .bottom_o(bottom_o),
		.stage_one_setpoint_o(sv1_o), .stage_two_setpoint_o(sv2_o), .setpoint_upper_bound_o(ub_o),
		.control_output_one_o(control_output_one), .control_output_two_o(control_output_two), .transistor_out_o(trans_o),
		.second_out_o(second_o), .colour_o(colour_o), .on_count_one_o(cnt1_o), .on_count_two_o(),
		.count_alarm_o(count_alarm_o));
	tol_sensor_model sensor (.mclk_i(mclk_i), .en_i(m_en), .sourcing_i(m_src), .on_cyc_i(m_on),
		.off_cyc_i(m_off), .sense_o(count_in_i));
	task automatic stop_test();
		if (fail_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	function automatic logic in_rng(input logic [19:0] v, input logic [19:0] lo, input logic [19:0] hi);
		return v >= lo && v <= hi;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic wait_stb(input int lim, output int c);
		c = 0;
		while (c < lim && meas_stb_o !== 1'b1)
		begin
			@(negedge mclk_i);
			c++;
		end
		chk("strobe", 24'(meas_stb_o), 24'h1);
	endtask
	task automatic sv_write(input logic s, input logic [19:0] v);
		@(posedge mclk_i);
		sv_wr_i <= '{1'b1, s, v};
		@(posedge mclk_i);
		sv_wr_i.wr <= 1'b0;
		tick(2);
	endtask
	task automatic set_sv(input logic s, input logic [19:0] v);
		int c;
		sv_write(s, v);
		wait_stb(3000, c);
		tick(4);
	endtask
	task automatic ub_write(input logic [19:0] v);
		@(posedge mclk_i);
		ub_wr_i <= 1'b1;
		ub_value_i <= v;
		@(posedge mclk_i);
		ub_wr_i <= 1'b0;
		tick(2);
	endtask
	task automatic col_sweep(input logic area, input logic want_on);
		for (int i = 0; i < 9; i++)
		begin
			@(posedge mclk_i);
			cfg_i.area_mode <= area;
			cfg_i.colour_sel <= tol_colour_sel_t'(i);
			tick(3);
			chk("colour", 24'(colour_o), 24'(want_on ? col_on[i] : col_off[i]));
		end
	endtask
	initial
	begin
		int stb;
		repeat (5) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		tick(1);
		chk("colour rst", 24'(colour_o), 24'(TOL_RED));
		chk("bottom rst", 24'(bottom_o), 24'(BOTTOM_RST));
		chk("bound rst", 24'(ub_o), 24'(VAL_MAX));
		// inhibit window: no strobe, output one off
		stb = 0;
		for (int i = 0; i < 1500; i++)
		begin
			tick(1);
			stb += (meas_stb_o === 1'b1) || (control_output_one !== 1'b0);
		end
		chk("inhibit", 24'(stb), 24'h0);
		chk("startup", 24'(startup_done_o), 24'h0);
		tick(700);
		chk("startup", 24'(startup_done_o), 24'h1);
		ub_write(20'h00000);
		chk("bound low", 24'(ub_o), 24'(UB_MIN));
		ub_write(20'hFFFFF);
		chk("bound high", 24'(ub_o), 24'(VAL_MAX));
		ub_write(20'd1500);
		@(posedge mclk_i);
		run_mode_i <= 1'b1;
		sv_write(1'b0, 20'd2000);
		chk("sv clamp", 24'(sv1_o), 24'd1500);
		@(posedge mclk_i);
		run_mode_i <= 1'b0;
		sv_write(1'b1, 20'd1500);
		chk("sv two", 24'(sv2_o), 24'd1500);
		set_sv(1'b0, 20'd800);
		chk("period", 24'(in_rng(meas_value_o, 20'd999, 20'd1001)), 24'h1);
		chk("out one", {22'h0, control_output_one, control_output_two}, 24'h2);
		chk("alloc off", {22'h0, trans_o, second_o}, 24'h2);
		@(posedge mclk_i);
		cfg_i.stage_alloc <= 1'b1;
		tick(3);
		chk("alloc on", {22'h0, trans_o, second_o}, 24'h1);
		col_sweep(1'b0, 1'b1);
		col_sweep(1'b1, 1'b1);
		sv_write(1'b0, 20'd1500);
		set_sv(1'b1, 20'd800);
		chk("out two", {22'h0, control_output_one, control_output_two}, 24'h1);
		col_sweep(1'b0, 1'b1);
		col_sweep(1'b1, 1'b0);
		@(posedge mclk_i);
		cfg_i.area_mode <= 1'b0;
		set_sv(1'b0, 20'd950);
		chk("hyst on", 24'(control_output_one), 24'h1);
		set_sv(1'b0, 20'd1050);
		chk("hyst hold", 24'(control_output_one), 24'h1);
		set_sv(1'b0, 20'd1101);
		chk("hyst off", 24'(control_output_one), 24'h0);
		set_sv(1'b0, 20'd900);
		@(posedge mclk_i);
		offd <= 16'h0003;
		set_sv(1'b0, 20'd1500);
		tick(500);
		chk("delay hold", 24'(control_output_one), 24'h1);
		wait_stb(1500, cyc);
		chk("delay meas", 24'(in_rng(meas_value_o, 20'd999, 20'd1001)), 24'h1);
		tick(2500);
		chk("delay end", 24'(control_output_one), 24'h0);
		@(posedge mclk_i);
		offd <= 16'h0000;
		thr1 <= 14'h0002;
		nv1 <= '{14'h0001, 10'h3E7};
		nv_load_i <= 1'b1;
		@(posedge mclk_i);
		nv_load_i <= 1'b0;
		tick(3);
		chk("peak load", 24'(peak_o), 24'h12345);
		chk("count load", 24'(cnt1_o), 24'h0007E7);
		set_sv(1'b0, 20'd900);
		chk("count kilo", 24'(cnt1_o), 24'h000800);
		chk("alarm edge", 24'(count_alarm_o), 24'h0);
		set_sv(1'b0, 20'd1500);
		set_sv(1'b0, 20'd900);
		chk("alarm", 24'(count_alarm_o), 24'h1);
		@(posedge mclk_i);
		thr1 <= 14'h0000;
		tick(4);
		chk("alarm off", 24'(count_alarm_o), 24'h0);
		@(posedge mclk_i);
		cfg_i.unit_period <= 1'b0;
		cfg_change_i <= 1'b1;
		@(posedge mclk_i);
		cfg_change_i <= 1'b0;
		tick(2);
		chk("bottom restart", 24'(bottom_o), 24'(BOTTOM_RST));
		wait_stb(12000, cyc);
		tick(1);
		wait_stb(12000, cyc);
		chk("gate cont", 24'(cyc >= 9999 && cyc <= 10001), 24'h1);
		chk("hertz", 24'(in_rng(meas_value_o, 20'd900, 20'd1100)), 24'h1);
		chk("bottom", 24'(in_rng(bottom_o, 20'd900, 20'd1100)), 24'h1);
		chk("peak kept", 24'(peak_o), 24'h12345);
		@(posedge mclk_i);
		m_en <= 1'b0;
		m_src <= 1'b0;
		m_on <= 16'd50;
		m_off <= 16'd21000;
		cfg_i.sourcing <= 1'b0;
		cfg_i.pulse_width <= 1'b1;
		cfg_change_i <= 1'b1;
		@(posedge mclk_i);
		cfg_change_i <= 1'b0;
		m_en <= 1'b1;
		tick(2);
		wait_stb(25000, cyc);
		chk("width", 24'(in_rng(meas_value_o, 20'd49, 20'd51)), 24'h1);
		@(posedge mclk_i);
		m_en <= 1'b0;
		stb = 0;
		for (int i = 0; i < 3000; i++)
		begin
			tick(1);
			stb += (meas_stb_o === 1'b1);
		end
		chk("width held", {22'h0, stb != 0, in_rng(meas_value_o, 20'd49, 20'd51)}, 24'h1);
		stop_test();
	end
	initial
	begin
		repeat (90000) @(posedge mclk_i);
		fail_count++;
		stop_test();
	end
endmodule
